//--- design/hbsc_bridge.sv
// Purpose: fault latches and switch drive of one half-bridge
// Assumes: detector inputs are asynchronous levels from the analog side
// Notes: every latch lets a new fault win over a clear in the same cycle
`timescale 1ns/1ps

module hbsc_bridge (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Async reset, active high
  input wire logic oc_detect, // Overcurrent detector, async
  input wire logic ul_detect, // Underload detector, async
  input wire logic tsd_detect, // Over-temperature detector, async
  input wire logic bridge_output_enable, // 1 drives, 0 high impedance
  input wire logic bridge_polarity, // 1 high side on, 0 low side on
  input wire logic underload_shutdown_enable, // Underload turns bridge off
  input wire logic clear_req, // One-cycle flag clear
  input wire logic lockout, // Supply overvoltage lockout active
  input wire logic drive_gate, // Enable pin, synchronised
  output logic hs_on, // High-side switch command
  output logic ls_on, // Low-side switch command
  output logic overcurrent_flag, // Latched overcurrent
  output logic underload_flag, // Latched underload
  output logic tsd_flag, // Latched thermal shutdown
  output logic [1:0] bridge_state_code // Priority-encoded state
);

  logic [2:0] s1_r, s1_nxt, s2_r, s2_nxt;
  logic oc_r, oc_nxt, ul_r, ul_nxt, tsd_r, tsd_nxt;
  logic hs_r, hs_nxt, ls_r, ls_nxt;
  logic drive_on;
  hbsc_pkg::hbsc_code_e code;

  // Synchronisers, then latches where a fresh fault beats the clear
  always_comb begin
    s1_nxt = {oc_detect, ul_detect, tsd_detect};
    s2_nxt = s1_r;
    oc_nxt = s2_r[2] | (oc_r & ~clear_req);
    ul_nxt = s2_r[1] | (ul_r & ~clear_req);
    // A still-hot bridge stays latched off through a clear
    tsd_nxt = s2_r[0] | (tsd_r & ~clear_req);
    drive_on = bridge_output_enable & drive_gate & ~lockout;
    drive_on = drive_on & ~oc_r & ~tsd_r;
    drive_on = drive_on & ~(ul_r & underload_shutdown_enable);
    hs_nxt = drive_on & bridge_polarity;
    ls_nxt = drive_on & ~bridge_polarity;
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r <= 3'h0;
      s2_r <= 3'h0;
      oc_r <= 1'b0;
      ul_r <= 1'b0;
      tsd_r <= 1'b0;
      hs_r <= 1'b0;
      ls_r <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      oc_r <= oc_nxt;
      ul_r <= ul_nxt;
      tsd_r <= tsd_nxt;
      hs_r <= hs_nxt;
      ls_r <= ls_nxt;
    end
  end

  // Overcurrent outranks underload, which outranks plain enable
  always_comb begin
    if (oc_r) begin
      code = hbsc_pkg::HBSC_CODE_OC;
    end else if (ul_r) begin
      code = hbsc_pkg::HBSC_CODE_UL;
    end else if (bridge_output_enable) begin
      code = hbsc_pkg::HBSC_CODE_ON;
    end else begin
      code = hbsc_pkg::HBSC_CODE_OFF;
    end
  end

  assign hs_on = hs_r;
  assign ls_on = ls_r;
  assign overcurrent_flag = oc_r;
  assign underload_flag = ul_r;
  assign tsd_flag = tsd_r;
  assign bridge_state_code = code;

endmodule : hbsc_bridge

//--- design/hbsc_defines.svh
// Purpose: bit positions, reset values and timing figures of the port
// Assumes: 16-bit command and status words, system clock at 50 MHz
// Notes: host-side times are kept for the bench; the logic reads none
`ifndef HBSC_DEFINES_SVH
`define HBSC_DEFINES_SVH

// Command word fields
`define HBSC_CMD_CLR 15
`define HBSC_CMD_GRP 14
`define HBSC_CMD_ULSD 13
`define HBSC_CMD_EN_HI 12
`define HBSC_CMD_EN_LO 7
`define HBSC_CMD_POL_HI 6
`define HBSC_CMD_POL_LO 1
`define HBSC_CMD_OV_LOCK 0

// Status word fields
`define HBSC_ST_OC 15
`define HBSC_ST_SUPPLY 14
`define HBSC_ST_UL 13
`define HBSC_ST_CODE_HI 12
`define HBSC_ST_CODE_LO 1
`define HBSC_ST_SPARE 0

// Group slices of the 12-bridge vectors, bridge n at index n-1
`define HBSC_HI_TOP 11
`define HBSC_HI_BOT 6
`define HBSC_LO_TOP 5
`define HBSC_LO_BOT 0
`define HBSC_CODE_HI_TOP 23
`define HBSC_CODE_HI_BOT 12
`define HBSC_CODE_LO_TOP 11
`define HBSC_CODE_LO_BOT 0

// Frame bit counts
`define HBSC_LAST_CNT 5'h0f
`define HBSC_FULL_CNT 5'h10

// Reset values
`define HBSC_RST_WORD 16'h0000
`define HBSC_RST_SYNC 5'h10

// Timing, system clock period and host obligations
`define HBSC_CLK_NS 20
`define HBSC_SO_EN_MAX_NS 200
`define HBSC_SO_EN_MAX_CYC (`HBSC_SO_EN_MAX_NS / `HBSC_CLK_NS)
`define HBSC_CS_HIGH_MIN_NS 5000
`define HBSC_CS_HIGH_MIN_CYC ((`HBSC_CS_HIGH_MIN_NS + `HBSC_CLK_NS - 1) / `HBSC_CLK_NS)
`define HBSC_CLR_GAP_MIN_US 150
`define HBSC_EN_VALID_MAX_US 100
`define HBSC_EN_LOW_MIN_US 10

`endif

//--- design/hbsc_pkg.sv
// Purpose: shared types of the half-bridge serial port
// Assumes: nothing beyond the defines header
// Notes: state codes are priority encoded per bridge
package hbsc_pkg;

  // Per-bridge output state code
  typedef enum logic [1:0] {
    HBSC_CODE_OFF = 2'h0,
    HBSC_CODE_OC = 2'h1,
    HBSC_CODE_UL = 2'h2,
    HBSC_CODE_ON = 2'h3
  } hbsc_code_e;

  // One command or status word
  typedef logic [15:0] hbsc_word_t;

endpackage : hbsc_pkg

//--- design/hbsc_top.sv
// Purpose: serial command and status port of a 12-channel half-bridge driver
// Assumes: link shifts SO on serial_clk rise and samples SI on its fall
// Notes: power stage and analog detectors sit outside as plain levels
`timescale 1ns/1ps
`include "hbsc_defines.svh"

module hbsc_top #(
  parameter int unsigned NUM_BRIDGES = 12 // Half-bridge count
) (
  input wire logic clk, // System clock, 50 MHz
  input wire logic sys_rst, // Async reset, active high
  input wire logic serial_clk, // Link clock from host
  input wire logic chip_select_n, // Frame select, active low
  input wire logic serial_in, // Command data from host
  output logic serial_out, // Status data to host
  output logic serial_out_oe, // Drive enable for serial_out
  input wire logic drive_enable, // Enable pin, high to run
  input wire logic [NUM_BRIDGES-1:0] oc_detect, // Overcurrent per bridge
  input wire logic [NUM_BRIDGES-1:0] ul_detect, // Underload per bridge
  input wire logic [NUM_BRIDGES-1:0] tsd_detect, // Over-temp per bridge
  input wire logic vs_overvoltage, // Either supply over limit
  input wire logic vs_undervoltage, // Either supply under limit
  output logic [NUM_BRIDGES-1:0] hs_on, // High-side switch commands
  output logic [NUM_BRIDGES-1:0] ls_on // Low-side switch commands
);

  // The word layout fixes two groups of six
  if (NUM_BRIDGES != 12) begin : g_bad_count
    $error("hbsc_top serves exactly twelve bridges");
  end

  // ---- Link domain, clocked by serial_clk ----

  // Closing the frame resets the shifters, so a short frame is dropped
  logic link_rst;
  assign link_rst = sys_rst | chip_select_n;

  hbsc_pkg::hbsc_word_t rx_sh_r, rx_sh_nxt;
  logic [4:0] rx_cnt_r, rx_cnt_nxt;

  // Receive shifter, sampled on the falling edge
  always_comb begin
    rx_sh_nxt = {rx_sh_r[14:0], serial_in};
    rx_cnt_nxt = rx_cnt_r;
    if (rx_cnt_r != `HBSC_FULL_CNT) begin
      rx_cnt_nxt = rx_cnt_r + 5'h01;
    end
  end

  always_ff @(negedge serial_clk or posedge link_rst) begin
    if (link_rst) begin
      rx_sh_r <= `HBSC_RST_WORD;
      rx_cnt_r <= 5'h00;
    end else begin
      rx_sh_r <= rx_sh_nxt;
      rx_cnt_r <= rx_cnt_nxt;
    end
  end

  hbsc_pkg::hbsc_word_t word_r, word_nxt;
  logic word_tgl_r, word_tgl_nxt;

  // Sixteenth bit completes the word; later bits are ignored
  always_comb begin
    word_nxt = word_r;
    word_tgl_nxt = word_tgl_r;
    if (rx_cnt_r == `HBSC_LAST_CNT) begin
      word_nxt = rx_sh_nxt;
      word_tgl_nxt = ~word_tgl_r;
    end
  end

  // Word and toggle survive chip select so the system side can fetch them
  always_ff @(negedge serial_clk or posedge sys_rst) begin
    if (sys_rst) begin
      word_r <= `HBSC_RST_WORD;
      word_tgl_r <= 1'b0;
    end else begin
      word_r <= word_nxt;
      word_tgl_r <= word_tgl_nxt;
    end
  end

  hbsc_pkg::hbsc_word_t tx_sh_r, tx_sh_nxt;
  hbsc_pkg::hbsc_word_t snap_r, snap_nxt;
  logic snap_tsd_r, snap_tsd_nxt;
  logic tx_first_r, tx_first_nxt;
  logic so_r, so_nxt;

  // Transmit: first rising edge shows the thermal flag, then 15 downward
  always_comb begin
    tx_sh_nxt = {tx_sh_r[14:0], 1'b0};
    so_nxt = tx_sh_r[15];
    tx_first_nxt = 1'b0;
    if (tx_first_r) begin
      // Snapshot is frozen before the first edge, see below
      so_nxt = snap_tsd_r;
      tx_sh_nxt = snap_r;
    end
  end

  always_ff @(posedge serial_clk or posedge link_rst) begin
    if (link_rst) begin
      tx_sh_r <= `HBSC_RST_WORD;
      tx_first_r <= 1'b1;
      so_r <= 1'b0;
    end else begin
      tx_sh_r <= tx_sh_nxt;
      tx_first_r <= tx_first_nxt;
      so_r <= so_nxt;
    end
  end

  assign serial_out = so_r;

  // ---- System domain, clocked by clk ----

  // Two-flop synchronisers: select, enable, word toggle, supply faults
  logic [4:0] s1_r, s1_nxt, s2_r, s2_nxt;
  logic sel_d3_r, sel_d3_nxt, tgl_d3_r, tgl_d3_nxt;
  logic sel_s, en_s, tgl_s, ov_s, uv_s;

  always_comb begin
    s1_nxt = {chip_select_n, drive_enable, word_tgl_r, vs_overvoltage, vs_undervoltage};
    s2_nxt = s1_r;
    sel_d3_nxt = s2_r[4];
    tgl_d3_nxt = s2_r[2];
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r <= `HBSC_RST_SYNC;
      s2_r <= `HBSC_RST_SYNC;
      sel_d3_r <= 1'b1;
      tgl_d3_r <= 1'b0;
    end else begin
      s1_r <= s1_nxt;
      s2_r <= s2_nxt;
      sel_d3_r <= sel_d3_nxt;
      tgl_d3_r <= tgl_d3_nxt;
    end
  end

  assign sel_s = s2_r[4];
  assign en_s = s2_r[3];
  assign tgl_s = s2_r[2];
  assign ov_s = s2_r[1];
  assign uv_s = s2_r[0];

  // Word is stable here: it cannot change until the next full frame
  logic cmd_stb, frame_open;
  assign cmd_stb = tgl_s ^ tgl_d3_r;
  assign frame_open = sel_d3_r & ~sel_s;

  logic [NUM_BRIDGES-1:0] en_r, en_nxt, pol_r, pol_nxt, clr_r, clr_nxt;
  logic [1:0] ulsd_r, ulsd_nxt;
  logic ov_lock_r, ov_lock_nxt, grp_r, grp_nxt;

  // Command decode; enable pin low resets every setting and holds the clear on every flag, so a flag shows only a live fault
  always_comb begin
    en_nxt = en_r;
    pol_nxt = pol_r;
    ulsd_nxt = ulsd_r;
    ov_lock_nxt = ov_lock_r;
    grp_nxt = grp_r;
    clr_nxt = '0;
    if (!en_s) begin
      en_nxt = '0;
      pol_nxt = '0;
      ulsd_nxt = 2'h0;
      ov_lock_nxt = 1'b0;
      grp_nxt = 1'b0;
      clr_nxt = '1;
    end else if (cmd_stb) begin
      if (word_r[`HBSC_CMD_GRP]) begin
        en_nxt[`HBSC_HI_TOP:`HBSC_HI_BOT] = word_r[`HBSC_CMD_EN_HI:`HBSC_CMD_EN_LO];
        pol_nxt[`HBSC_HI_TOP:`HBSC_HI_BOT] = word_r[`HBSC_CMD_POL_HI:`HBSC_CMD_POL_LO];
        ulsd_nxt[1] = word_r[`HBSC_CMD_ULSD];
        if (word_r[`HBSC_CMD_CLR]) begin
          clr_nxt[`HBSC_HI_TOP:`HBSC_HI_BOT] = '1;
        end
      end else begin
        en_nxt[`HBSC_LO_TOP:`HBSC_LO_BOT] = word_r[`HBSC_CMD_EN_HI:`HBSC_CMD_EN_LO];
        pol_nxt[`HBSC_LO_TOP:`HBSC_LO_BOT] = word_r[`HBSC_CMD_POL_HI:`HBSC_CMD_POL_LO];
        ulsd_nxt[0] = word_r[`HBSC_CMD_ULSD];
        if (word_r[`HBSC_CMD_CLR]) begin
          clr_nxt[`HBSC_LO_TOP:`HBSC_LO_BOT] = '1;
        end
      end
      ov_lock_nxt = word_r[`HBSC_CMD_OV_LOCK];
      grp_nxt = word_r[`HBSC_CMD_GRP];
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      en_r <= '0;
      pol_r <= '0;
      ulsd_r <= 2'h0;
      ov_lock_r <= 1'b0;
      grp_r <= 1'b0;
      clr_r <= '0;
    end else begin
      en_r <= en_nxt;
      pol_r <= pol_nxt;
      ulsd_r <= ulsd_nxt;
      ov_lock_r <= ov_lock_nxt;
      grp_r <= grp_nxt;
      clr_r <= clr_nxt;
    end
  end

  // Lockout is not latched, so outputs resume once the supply recovers
  logic lockout;
  assign lockout = ov_lock_r & ov_s;

  logic [NUM_BRIDGES-1:0] oc_flag, ul_flag, tsd_flag;
  logic [2*NUM_BRIDGES-1:0] codes;

  // One bridge slice per channel; the upper six share group 1 settings
  for (genvar i = 0; i < NUM_BRIDGES; i++) begin : g_bridge
    hbsc_bridge u_bridge (
      .clk(clk),
      .sys_rst(sys_rst),
      .oc_detect(oc_detect[i]),
      .ul_detect(ul_detect[i]),
      .tsd_detect(tsd_detect[i]),
      .bridge_output_enable(en_r[i]),
      .bridge_polarity(pol_r[i]),
      .underload_shutdown_enable(ulsd_r[i / 6]),
      .clear_req(clr_r[i]),
      .lockout(lockout),
      .drive_gate(en_s),
      .hs_on(hs_on[i]),
      .ls_on(ls_on[i]),
      .overcurrent_flag(oc_flag[i]),
      .underload_flag(ul_flag[i]),
      .tsd_flag(tsd_flag[i]),
      .bridge_state_code(codes[2*i+1:2*i])
    );
  end

  // Status word for the group the last committed command chose
  hbsc_pkg::hbsc_word_t status_w;
  always_comb begin
    status_w = `HBSC_RST_WORD;
    status_w[`HBSC_ST_SUPPLY] = ov_s | uv_s;
    if (grp_r) begin
      status_w[`HBSC_ST_OC] = |oc_flag[`HBSC_HI_TOP:`HBSC_HI_BOT];
      status_w[`HBSC_ST_UL] = |ul_flag[`HBSC_HI_TOP:`HBSC_HI_BOT];
      status_w[`HBSC_ST_CODE_HI:`HBSC_ST_CODE_LO] =
        codes[`HBSC_CODE_HI_TOP:`HBSC_CODE_HI_BOT];
    end else begin
      status_w[`HBSC_ST_OC] = |oc_flag[`HBSC_LO_TOP:`HBSC_LO_BOT];
      status_w[`HBSC_ST_UL] = |ul_flag[`HBSC_LO_TOP:`HBSC_LO_BOT];
      status_w[`HBSC_ST_CODE_HI:`HBSC_ST_CODE_LO] =
        codes[`HBSC_CODE_LO_TOP:`HBSC_CODE_LO_BOT];
    end
  end

  logic so_oe_r, so_oe_nxt;

  // Freeze status when select falls; it then holds for the whole frame,
  // which the link side reads without a further crossing
  always_comb begin
    snap_nxt = snap_r;
    snap_tsd_nxt = snap_tsd_r;
    so_oe_nxt = ~sel_s;
    if (frame_open) begin
      snap_nxt = status_w;
      snap_tsd_nxt = |tsd_flag;
    end
  end

  always_ff @(posedge clk or posedge sys_rst) begin
    if (sys_rst) begin
      snap_r <= `HBSC_RST_WORD;
      snap_tsd_r <= 1'b0;
      so_oe_r <= 1'b0;
    end else begin
      snap_r <= snap_nxt;
      snap_tsd_r <= snap_tsd_nxt;
      so_oe_r <= so_oe_nxt;
    end
  end

  assign serial_out_oe = so_oe_r;

endmodule : hbsc_top

//--- tb/hbsc_host_model.sv
// Purpose: host side of the serial link, bus master model
// Assumes: data changes on link rise, device samples on link fall
// Notes: link clock stands still between frames
`timescale 1ns/1ps

module hbsc_host_model (
  output logic serial_clk, // Link clock, idle low
  output logic chip_select_n, // Frame select, active low
  output logic serial_in, // Command bits
  input wire logic serial_out, // Status bits
  input wire logic serial_out_oe // Device drive enable of status line
);
  realtime last_clr = -1.0e9;

  // Idle link at time zero
  initial begin
    serial_clk = 1'b0;
    chip_select_n = 1'b1;
    serial_in = 1'b0;
  end

  // One 16-bit frame, captured bits returned most significant first
  task automatic xfer(input hbsc_pkg::hbsc_word_t cmd, output logic [15:0] cap);
    if (cmd[15] && ($realtime - last_clr < 150000.0))
      #(150000.0 - ($realtime - last_clr));
    if (cmd[15])
      last_clr = $realtime;
    chip_select_n = 1'b0;
    serial_in = cmd[15];
    #128;
    for (int k = 0; k < 16; k++) begin
      serial_clk = 1'b1;
      if (k > 0)
        serial_in = cmd[15-k];
      // Undriven line reads inverted, so a late enable shows up as a bad bit
      #31 cap[15-k] = serial_out_oe ? serial_out : ~serial_out;
      #1 serial_clk = 1'b0;
      #32;
    end
    chip_select_n = 1'b1;
    serial_in = ~serial_in; // Released line shows no stale bit
    #5000;
  endtask : xfer
endmodule : hbsc_host_model

//--- tb/hbsc_top_properties.sv
// Purpose: port-level checks of the half-bridge serial port
// Assumes: link signals sampled in the system clock domain
// Notes: link edges are async, so windows allow one extra clk
`timescale 1ns/1ps

module hbsc_props #(
  parameter int unsigned NUM_BRIDGES = 12 // Half-bridge count
) (
  input wire logic clk, // System clock
  input wire logic sys_rst, // Async reset
  input wire logic serial_clk, // Link clock
  input wire logic chip_select_n, // Frame select
  input wire logic serial_out, // Status data
  input wire logic serial_out_oe, // Drive enable
  input wire logic drive_enable, // Enable pin
  input wire logic [NUM_BRIDGES-1:0] oc_detect, // Overcurrent detectors
  input wire logic [NUM_BRIDGES-1:0] hs_on, // High-side commands
  input wire logic [NUM_BRIDGES-1:0] ls_on // Low-side commands
);
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (sys_rst);

  // Output enable follows the select line
  property p_oe_on;
    $fell(chip_select_n) |-> ##[1:3] serial_out_oe;
  endproperty
  property p_oe_off;
    $rose(chip_select_n) |-> ##[1:4] !serial_out_oe;
  endproperty
  property p_oe_idle;
    chip_select_n [*5] |-> !serial_out_oe;
  endproperty
  // Data only moves on a link rise while selected
  property p_so_steady;
    (!serial_clk && !$past(serial_clk) && !chip_select_n && !$past(chip_select_n))
      |-> $stable(serial_out);
  endproperty
  // Switch commands
  property p_one_side;
    (hs_on & ls_on) == '0;
  endproperty
  property p_sleep_off;
    !drive_enable [*5] |-> ((hs_on | ls_on) == '0);
  endproperty
  property p_oc_off;
    ((hs_on | ls_on) & oc_detect & $past(oc_detect, 5)) == '0;
  endproperty
  property p_rst_zero;
    $fell(sys_rst) |-> !serial_out_oe && ((hs_on | ls_on) == '0);
  endproperty

  a_oe_on: assert property (p_oe_on) else $error("oe late after select");
  a_oe_off: assert property (p_oe_off) else $error("oe held after select");
  a_oe_idle: assert property (p_oe_idle) else $error("oe while idle");
  a_so_steady: assert property (p_so_steady) else $error("so moved off edge");
  a_one_side: assert property (p_one_side) else $error("both sides on");
  a_sleep_off: assert property (p_sleep_off) else $error("drive while asleep");
  a_oc_off: assert property (p_oc_off) else $error("drive after overcurrent");
  a_rst_zero: assert property (p_rst_zero) else $error("outputs after reset");

  c_frame: cover property ($fell(chip_select_n));
  c_high: cover property (|hs_on);
  c_low: cover property (|ls_on);
endmodule : hbsc_props

bind hbsc_top hbsc_props #(.NUM_BRIDGES(NUM_BRIDGES)) u_hbsc_props (
  .clk(clk), .sys_rst(sys_rst), .serial_clk(serial_clk), .chip_select_n(chip_select_n),
  .serial_out(serial_out), .serial_out_oe(serial_out_oe), .drive_enable(drive_enable),
  .oc_detect(oc_detect), .hs_on(hs_on), .ls_on(ls_on));

//--- tb/tb_top.sv
// Purpose: self-checking bench of the half-bridge serial port
// Assumes: host model drives the link, bench drives pins on clk rise
// Notes: detector pulses are held long enough for the 2-flop syncs
`timescale 1ns/1ps

module tb_top;
  localparam logic [5:0] ENA = 6'h2d;
  localparam logic [5:0] POA = 6'h26;
  localparam logic [5:0] ENB = 6'h33;
  localparam logic [5:0] POB = 6'h19;
  localparam hbsc_pkg::hbsc_word_t C0 = {3'h0, ENA, POA, 1'b0}; // Low group setup
  localparam hbsc_pkg::hbsc_word_t C1 = {3'h2, ENB, POB, 1'b0}; // High group setup
  localparam logic [11:0] HS = {ENB & POB, ENA & POA};
  localparam logic [11:0] LS = {ENB & ~POB, ENA & ~POA};
  localparam int CEIL = 60000; // About two and a half times the planned run
  logic clk, sys_rst, serial_clk, chip_select_n, serial_in, serial_out, serial_out_oe;
  logic drive_enable, vs_overvoltage, vs_undervoltage;
  logic [11:0] oc_detect, ul_detect, tsd_detect, hs_on, ls_on;
  int err_total = 0;
  int total_checks = 0;
  int cycles = 0;

  // 50 MHz system clock
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end

  hbsc_top u_hbsc_top (
    .clk(clk), .sys_rst(sys_rst), .serial_clk(serial_clk), .chip_select_n(chip_select_n),
    .serial_in(serial_in), .serial_out(serial_out), .serial_out_oe(serial_out_oe),
    .drive_enable(drive_enable), .oc_detect(oc_detect), .ul_detect(ul_detect),
    .tsd_detect(tsd_detect), .vs_overvoltage(vs_overvoltage),
    .vs_undervoltage(vs_undervoltage), .hs_on(hs_on), .ls_on(ls_on));

  hbsc_host_model u_hbsc_host_model (
    .serial_clk(serial_clk), .chip_select_n(chip_select_n), .serial_in(serial_in),
    .serial_out(serial_out), .serial_out_oe(serial_out_oe));

  task automatic conclude();
    $display("checks %0d mismatches %0d", total_checks, err_total);
    if (err_total == 0 && total_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : conclude

  task automatic chk_word(input string name, input logic [15:0] exp, input logic [15:0] got);
    total_checks++;
    if (got !== exp) begin
      err_total++;
      $display("unexpected %s exp %h got %h", name, exp, got);
    end
  endtask : chk_word

  // Both switch vectors against the programmed pattern under a mask
  task automatic chk_pins(input logic [11:0] m);
    total_checks++;
    if (hs_on !== (HS & m) || ls_on !== (LS & m)) begin
      err_total++;
      $display("unexpected switches exp %h %h got %h %h", HS & m, LS & m, hs_on, ls_on);
    end
  endtask : chk_pins

  // Status word of one group, bridge 12 or 6 in the top code
  function automatic logic [15:0] st(input logic [5:0] en, input logic [5:0] oc,
      input logic [5:0] ul, input logic sup);
    logic [15:0] s;
    s = {|oc, sup, |ul, 13'h0000};
    for (int i = 0; i < 6; i++) begin
      s[2*i+1 +: 2] = oc[i] ? 2'h1 : (ul[i] ? 2'h2 : (en[i] ? 2'h3 : 2'h0));
    end
    return s;
  endfunction : st

  // One frame, then status and switches; bit 0 never leaves the device
  task automatic step(input hbsc_pkg::hbsc_word_t cmd, input logic t, input logic [15:0] e,
      input logic [11:0] m);
    logic [15:0] cap;
    u_hbsc_host_model.xfer(cmd, cap);
    chk_word("status", {t, e[15:1]}, cap);
    chk_pins(m);
  endtask : step

  // Main sequence
  initial begin
    sys_rst = 1'b1;
    drive_enable = 1'b0;
    vs_overvoltage = 1'b0;
    vs_undervoltage = 1'b0;
    oc_detect = 12'h000;
    ul_detect = 12'h000;
    tsd_detect = 12'h000;
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    @(negedge clk);
    chk_pins(12'h000);
    @(posedge clk);
    drive_enable <= 1'b1;
    repeat (5000) @(posedge clk);
    step(C0, 1'b0, 16'h0000, 12'h03f);
    step(C1, 1'b0, st(ENA, 6'h00, 6'h00, 1'b0), 12'hfff);
    step(C0, 1'b0, st(ENB, 6'h00, 6'h00, 1'b0), 12'hfff);
    @(posedge clk);
    oc_detect <= 12'h080;
    repeat (10) @(posedge clk);
    step(C1, 1'b0, st(ENA, 6'h00, 6'h00, 1'b0), 12'hf7f);
    @(posedge clk);
    oc_detect <= 12'h000;
    step(C0 | 16'h8000, 1'b0, st(ENB, 6'h02, 6'h00, 1'b0), 12'hf7f);
    step(C1, 1'b0, st(ENA, 6'h00, 6'h00, 1'b0), 12'hf7f);
    step(C1 | 16'h8000, 1'b0, st(ENB, 6'h02, 6'h00, 1'b0), 12'hfff);
    step(C1, 1'b0, st(ENB, 6'h00, 6'h00, 1'b0), 12'hfff);
    step(C0, 1'b0, st(ENB, 6'h00, 6'h00, 1'b0), 12'hfff);
    @(posedge clk);
    tsd_detect <= 12'h400;
    repeat (10) @(posedge clk);
    tsd_detect <= 12'h000;
    @(negedge clk);
    chk_pins(12'hbff);
    step(C1 | 16'h8000, 1'b1, st(ENA, 6'h00, 6'h00, 1'b0), 12'hfff);
    step(C1, 1'b0, st(ENB, 6'h00, 6'h00, 1'b0), 12'hfff);
    @(posedge clk);
    ul_detect <= 12'h001;
    step(C0 | 16'h2000, 1'b0, st(ENB, 6'h00, 6'h00, 1'b0), 12'hffe);
    step(C0 | 16'h2000, 1'b0, st(ENA, 6'h00, 6'h01, 1'b0), 12'hffe);
    @(posedge clk);
    ul_detect <= 12'h000;
    vs_overvoltage <= 1'b1;
    // Let the supply fault pass its synchroniser before the snapshot
    repeat (4) @(posedge clk);
    step(C1 | 16'h0001, 1'b0, st(ENA, 6'h00, 6'h01, 1'b1), 12'h000);
    @(posedge clk);
    vs_overvoltage <= 1'b0;
    vs_undervoltage <= 1'b1;
    repeat (10) @(posedge clk);
    @(negedge clk);
    chk_pins(12'hffe);
    step(C1, 1'b0, st(ENB, 6'h00, 6'h00, 1'b1), 12'hffe);
    @(posedge clk);
    vs_undervoltage <= 1'b0;
    drive_enable <= 1'b0;
    repeat (500) @(posedge clk);
    @(negedge clk);
    chk_pins(12'h000);
    // Asleep: flags wiped, command refused, outputs stay off
    step(C0, 1'b0, 16'h0000, 12'h000);
    conclude();
  end

  // Cut a hung run short
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == CEIL) begin
      err_total++;
      conclude();
    end
  end
endmodule : tb_top
